//--- rtl/srbs_pkg.sv
// Package for the serial readback and status block.
// Assumes a single 25 MHz system clock and a four-wire serial link.
package srbs_pkg;
    // ==========================================================
    // Frame layout.
    localparam int FRAME_BITS = 24;
    localparam int RNW_BIT = 23;
    localparam int ADDR_HI_BIT = 22;
    localparam int ADDR_LO_BIT = 21;
    localparam int SEL_MSB = 20;
    localparam int SEL_LSB = 16;
    localparam int REG_ADDR_MSB = 20;
    localparam int REG_ADDR_LSB = 16;
    // ==========================================================
    // Read select codes.
    localparam logic [4:0] SEL_DATA = 5'h00;
    localparam logic [4:0] SEL_CTRL = 5'h04;
    localparam logic [4:0] SEL_GAIN = 5'h08;
    localparam logic [4:0] SEL_OFFS = 5'h0C;
    localparam logic [4:0] SEL_CLR = 5'h10;
    localparam logic [4:0] SEL_SLEW = 5'h14;
    localparam logic [4:0] SEL_STATUS = 5'h18;
    localparam logic [4:0] SEL_MAIN = 5'h19;
    localparam logic [4:0] SEL_BOOST = 5'h1A;
    // ==========================================================
    // Write address codes for the register groups (chosen layout).
    localparam logic [2:0] WR_DATA = 3'h0;
    localparam logic [2:0] WR_GAIN = 3'h1;
    localparam logic [2:0] WR_OFFS = 3'h2;
    localparam logic [2:0] WR_CLR = 3'h3;
    localparam logic [2:0] WR_CTRL = 3'h4;
    localparam logic [2:0] WR_SW = 3'h5;
    localparam logic [2:0] WR_MAIN = 3'h6;
    localparam logic [2:0] WR_BOOST = 3'h7;
    localparam int WR_MSB = 20;
    localparam int WR_LSB = 18;
    localparam int CH_MSB = 17;
    localparam int CH_LSB = 16;
    // Control word subcodes in D15..D13.
    localparam logic [2:0] CTL_SLEW = 3'h0;
    // ==========================================================
    // Slew word fields.
    localparam int SLEW_EN_BIT = 12;
    localparam int SLEW_RATE_MSB = 6;
    localparam int SLEW_RATE_LSB = 3;
    localparam int SLEW_STEP_MSB = 2;
    localparam int SLEW_STEP_LSB = 0;
    // Main control echo enable position (chosen).
    localparam int ECHO_BIT = 11;
    // Software register user toggle position (chosen).
    localparam int TOGGLE_BIT = 12;
    // ==========================================================
    // Status word fields.
    localparam int ST_BOOST_LSB = 12;
    localparam int ST_TOGGLE = 11;
    localparam int ST_PEC = 10;
    localparam int ST_RAMP = 9;
    localparam int ST_OTEMP = 8;
    localparam int ST_VF_LSB = 4;
    localparam int ST_IF_LSB = 0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [23:0] NOP_FRAME = 24'h1C_E000;
endpackage

//--- rtl/srbs_regs_if.sv
// Interface carrying a write strobe and readback between the frame
// logic and the register store.  Same clock on both sides.
`timescale 1ns/100ps
interface srbs_regs_if;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [15:0] wr_data;
    logic [4:0] rd_idx;
    logic [15:0] rd_data;
    modport ctl (output wr_en, output wr_idx, output wr_data,
        output rd_idx, input rd_data);
    modport mem (input wr_en, input wr_idx, input wr_data,
        input rd_idx, output rd_data);
endinterface

//--- rtl/srbs_store.sv
// Small memory of 32 sixteen-bit words with a registered read port.
// Assumes the caller on the same clock drives the interface.
`timescale 1ns/100ps
module srbs_store (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Register access.
    srbs_regs_if.mem bus
);
    import srbs_pkg::*;
    logic [15:0] mem_ff [32];

    // ==========================================================
    // Storage is written on a strobe; read data come from a flop.
    always_ff @(posedge mclk) begin
        if (bus.wr_en) begin
            mem_ff[bus.wr_idx] <= bus.wr_data;
        end
    end

    // Reset only clears the read flop; memory has no reset value.
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus.rd_data <= REG_RESET;
        end else begin
            bus.rd_data <= mem_ff[bus.rd_idx];
        end
    end
endmodule // srbs_store

//--- rtl/srbs_top.sv
// Serial slave frame logic, register readback and status word.
// Assumes serial pins arrive asynchronously and mclk is far faster.
//
// Operation
// - Top frame bit set marks the frame as a read request.
// - Device address bits plus five select bits pick the readback.
// - Low sixteen bits of a read request are ignored.
// - Next transfer shifts the selected register out on sdo.
// - No-op frame is 0x1CE000 with device address bits set.
// - Codes 0 to 3 return channel data registers.
// - Codes 4 to 7 return channel control registers.
// - Codes 8 to 11 return gain calibration registers.
// - Codes 12 to 15 return offset calibration registers.
// - Codes 16 to 19 return clear-code registers.
// - Codes 20 to 23 return slew control registers.
// - Codes 24, 25, 26 return status, main and boost control.
// - Slew word: subcode 000, enable bit 12, rate 6:3, step 2:0.
// - Slew settings are held and written per channel.
// - Slew limiting applies in current and voltage modes.
// - Status register is read-only.
// - With echo enabled, status shifts out during every write not right after a read.
// - With echo clear, status needs a read and a second frame.
// - Current mode compliance loss sets boost and current fault.
// - Voltage mode regulation failure sets the boost flag.
// - Boost flags never drive the fault pin.
// - User toggle follows the software register bit.
// - Packet check bit flags an error on the last word.
// - Ramp bit set while any enabled channel is still stepping.
// - Over-temperature bit follows the hot die indication.
`timescale 1ns/100ps
module srbs_top (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Serial link pins.
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    output logic sdo,
    // Device address straps.
    input wire logic device_addr_hi,
    input wire logic device_addr_lo,
    // Analog monitor inputs.
    input wire logic [3:0] current_mode,
    input wire logic [3:0] compliance_lost,
    input wire logic [3:0] boost_unregulated,
    input wire logic [3:0] vout_fault,
    input wire logic [3:0] iout_short,
    input wire logic over_temp,
    input wire logic packet_check_fail,
    input wire logic [3:0] ramping,
    // Fault pin, open drain.
    output logic fault_flag_pin_o,
    output logic fault_flag_pin_oe,
    // Per-channel slew settings.
    output logic [3:0] slew_enable,
    output logic [15:0] slew_update_rate,
    output logic [11:0] slew_step_size
);
    import srbs_pkg::*;

    srbs_regs_if regs ();

    // ==========================================================
    // Monitors and straps are not timed to mclk, so each passes two
    // flops; the status word lags the monitor pins by two cycles, except the packet check bit, which is taken at frame end.
    logic [27:0] mon1_ff;
    logic [27:0] mon2_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            mon1_ff <= 28'h000_0000;
            mon2_ff <= 28'h000_0000;
        end else begin
            mon1_ff <= {device_addr_hi, device_addr_lo, current_mode,
                compliance_lost, boost_unregulated, vout_fault,
                iout_short, ramping, over_temp, packet_check_fail};
            mon2_ff <= mon1_ff;
        end
    end
    wire addr_hi_s = mon2_ff[27];
    wire addr_lo_s = mon2_ff[26];
    wire [3:0] mode_s = mon2_ff[25:22];
    wire [3:0] comp_s = mon2_ff[21:18];
    wire [3:0] unreg_s = mon2_ff[17:14];
    wire [3:0] vflt_s = mon2_ff[13:10];
    wire [3:0] short_s = mon2_ff[9:6];
    wire [3:0] ramp_s = mon2_ff[5:2];
    wire hot_s = mon2_ff[1];
    wire pec_fail_s = mon2_ff[0];

    // ==========================================================
    // Two-stage synchronisers for the asynchronous pins.
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic sclk_prev_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_ff <= 3'h2; // Idle pin levels: no false link edge.
            sync2_ff <= 3'h2;
            sclk_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= {sclk, sync_n, sdin};
            sync2_ff <= sync1_ff;
            sclk_prev_ff <= sync2_ff[2];
        end
    end

    wire sclk_s = sync2_ff[2];
    wire frame_n = sync2_ff[1];
    wire din_s = sync2_ff[0];
    // Data are taken on the falling link edge and launched on rising.
    wire sclk_fall = sclk_prev_ff & ~sclk_s;
    wire sclk_rise = ~sclk_prev_ff & sclk_s;

    // ==========================================================
    // Frame shifter and bit counter.
    logic [23:0] shift_ff;
    logic [4:0] count_ff;
    logic frame_done_ff;
    logic frame_prev_ff;
    wire frame_start = frame_prev_ff & ~frame_n;
    wire frame_end = ~frame_prev_ff & frame_n;
    // Short frames are dropped; longer ones keep only their first 24 bits.
    wire frame_ok = frame_end & (count_ff == 5'(FRAME_BITS));
    always_ff @(posedge mclk) begin
        if (reset) begin
            shift_ff <= 24'h00_0000;
            count_ff <= 5'h00;
            frame_prev_ff <= 1'b1;
        end else begin
            frame_prev_ff <= frame_n;
            if (frame_start) begin
                count_ff <= 5'h00;
            end else if (!frame_n && sclk_fall
                && count_ff != 5'(FRAME_BITS)) begin
                shift_ff <= {shift_ff[22:0], din_s};
                count_ff <= count_ff + 5'h01;
            end
        end
    end

    // ==========================================================
    // Frame decode.
    wire addr_match = shift_ff[ADDR_HI_BIT] == addr_hi_s
        && shift_ff[ADDR_LO_BIT] == addr_lo_s;
    wire is_read = shift_ff[RNW_BIT];
    wire [4:0] sel = shift_ff[SEL_MSB:SEL_LSB];
    wire [2:0] wr_grp = shift_ff[WR_MSB:WR_LSB];
    wire [1:0] wr_ch = shift_ff[CH_MSB:CH_LSB];
    wire [15:0] wr_word = shift_ff[15:0];
    // The no-op pattern ignores address bits, which must match anyway.
    wire is_nop = {shift_ff[23], 2'b00, shift_ff[20:0]}
        == NOP_FRAME;
    wire accept = frame_ok & addr_match;
    wire take_read = accept & is_read & ~is_nop;
    wire take_write = accept & ~is_read & ~is_nop;
    // Only the slew subcode of the control group lands in slew words.
    wire is_slew = wr_grp == WR_CTRL
        && wr_word[15:13] == CTL_SLEW;

    // Store index: the write group maps onto the read select layout.
    logic [4:0] wr_base;
    always_comb begin
        unique case (wr_grp)
            WR_DATA: wr_base = SEL_DATA;
            WR_GAIN: wr_base = SEL_GAIN;
            WR_OFFS: wr_base = SEL_OFFS;
            WR_CLR: wr_base = SEL_CLR;
            WR_CTRL: wr_base = is_slew ? SEL_SLEW : SEL_CTRL;
            WR_SW: wr_base = SEL_STATUS;
            WR_MAIN: wr_base = SEL_MAIN;
            WR_BOOST: wr_base = SEL_BOOST;
        endcase
    end
    wire per_ch = wr_grp <= WR_CTRL;
    wire sw_write = take_write && wr_grp == WR_SW;
    // Status slot is never stored; software word only moves the toggle.
    assign regs.wr_en = take_write & ~(wr_grp == WR_SW);
    assign regs.wr_idx = per_ch ? (wr_base | {3'h0, wr_ch})
        : wr_base;
    assign regs.wr_data = wr_word;

    // ==========================================================
    // Shadow copies of slew and main control for the block's own logic.
    logic [15:0] slew_ff [4];
    logic echo_ff;
    logic toggle_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            echo_ff <= 1'b0;
            toggle_ff <= 1'b0;
        end else begin
            if (take_write && wr_grp == WR_MAIN) begin
                echo_ff <= wr_word[ECHO_BIT];
            end
            if (sw_write) begin
                toggle_ff <= wr_word[TOGGLE_BIT];
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_slew
            // Each channel keeps its own settings.
            always_ff @(posedge mclk) begin
                if (reset) begin
                    slew_ff[ch] <= REG_RESET;
                end else if (take_write && is_slew
                    && wr_ch == 2'(ch)) begin
                    slew_ff[ch] <= wr_word;
                end
            end
            // Used for both output types, no mode gating.
            assign slew_enable[ch] = slew_ff[ch][SLEW_EN_BIT];
            assign slew_update_rate[ch*4 +: 4] =
                slew_ff[ch][SLEW_RATE_MSB:SLEW_RATE_LSB];
            assign slew_step_size[ch*3 +: 3] =
                slew_ff[ch][SLEW_STEP_MSB:SLEW_STEP_LSB];
        end
    endgenerate

    // ==========================================================
    // Status word, built live from monitors; only the toggle bit has a write path.
    logic [3:0] boost_flag;
    logic [3:0] iout_flag;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_flag
            assign boost_flag[ch] = mode_s[ch]
                ? comp_s[ch]
                : unreg_s[ch];
            assign iout_flag[ch] = short_s[ch]
                | (mode_s[ch] & comp_s[ch]);
        end
    endgenerate
    logic pec_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pec_ff <= 1'b0;
        end else if (frame_ok) begin
            pec_ff <= pec_fail_s;
        end
    end
    wire ramp_active = |(ramp_s & slew_enable);
    wire [15:0] status_word = {boost_flag, toggle_ff, pec_ff,
        ramp_active, hot_s, vflt_s, iout_flag};

    // Boost flags are left out of the pin on purpose.
    wire fault_any = |vflt_s | |iout_flag | pec_ff | hot_s;
    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_flag_pin_o <= 1'b0;
            fault_flag_pin_oe <= 1'b1;
        end else begin
            fault_flag_pin_oe <= ~fault_any;
        end
    end

    // ==========================================================
    // Readback select held from the read frame until the next frame.
    logic [4:0] rd_sel_ff;
    logic rd_pend_ff;
    logic [1:0] load_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_sel_ff <= 5'h00;
            rd_pend_ff <= 1'b0;
        end else if (frame_ok) begin
            rd_pend_ff <= take_read;
            if (take_read) begin
                rd_sel_ff <= sel;
            end
        end
    end
    assign regs.rd_idx = rd_sel_ff;
    // Codes above the table read back as zero.
    wire sel_valid = rd_sel_ff <= SEL_BOOST;
    wire [15:0] rd_word = (rd_sel_ff == SEL_STATUS) ? status_word
        : (sel_valid ? regs.rd_data : REG_RESET);
    // slew words are stored at their select slots directly.

    // ==========================================================
    // Output shifter, loaded two cycles after frame start, 24 bits with data low.
    // Echo needs a frame that turns out to be a write; the status is
    // launched speculatively and only matters to the host then.
    logic [23:0] out_ff;
    wire [15:0] echo_word = echo_ff ? status_word : REG_RESET;
    always_ff @(posedge mclk) begin
        if (reset) begin
            out_ff <= 24'h00_0000;
            sdo <= 1'b0;
            load_ff <= 2'h0;
        end else begin
            load_ff <= {load_ff[0], frame_start};
            if (load_ff[1]) begin
                out_ff <= {3'h0, rd_sel_ff,
                    rd_pend_ff ? rd_word : echo_word};
                sdo <= 1'b0;
            end else if (!frame_n && sclk_rise) begin
                sdo <= out_ff[23];
                out_ff <= {out_ff[22:0], 1'b0};
            end
        end
    end
    // without echo, status comes only through rd_pend_ff path.

    srbs_store u_store (
        .mclk(mclk),
        .reset(reset),
        .bus(regs)
    );
endmodule // srbs_top

//--- tb/srbs_checker.sv
// Port-level checker for the serial readback and status block.
// Assumes it is bound to srbs_top and sees only that module's ports.
`timescale 1ns/100ps
module srbs_checker (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Serial pins.
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdo,
    // Monitor inputs.
    input wire logic [3:0] current_mode,
    input wire logic [3:0] compliance_lost,
    input wire logic [3:0] boost_unregulated,
    input wire logic [3:0] vout_fault,
    input wire logic [3:0] iout_short,
    input wire logic over_temp,
    input wire logic packet_check_fail,
    // Outputs.
    input wire logic fault_flag_pin_o,
    input wire logic fault_flag_pin_oe,
    input wire logic [3:0] slew_enable,
    input wire logic [15:0] slew_update_rate,
    input wire logic [11:0] slew_step_size
);
    // ==========================================================
    // Helper counters.
    logic [3:0] p_en_ff;
    logic [15:0] p_rate_ff;
    logic [11:0] p_step_ff;
    logic [18:0] p_flt_ff;
    logic p_sclk_ff;
    logic [3:0] hi_cnt_ff;
    logic [3:0] quiet_ff;
    logic [3:0] rise_cnt_ff;
    logic [4:0] rise_num_ff;
    wire [3:0] chg;
    wire [18:0] flt;
    wire rose;
    wire [3:0] nxt_hi_cnt;
    wire [3:0] nxt_quiet;
    wire [3:0] nxt_rise_cnt;
    wire [4:0] nxt_rise_num;
    // Counters other than rise_num_ff saturate at 15, so a long idle span reads as 15.
    assign flt = {current_mode, vout_fault, iout_short, compliance_lost,
        over_temp, packet_check_fail, sync_n};
    assign rose = sclk && !p_sclk_ff;
    assign nxt_hi_cnt = (reset || !sync_n) ? 4'h0 :
        hi_cnt_ff + {3'h0, hi_cnt_ff != 4'hF};
    assign nxt_quiet = (reset || flt != p_flt_ff) ? 4'h0 :
        quiet_ff + {3'h0, quiet_ff != 4'hF};
    assign nxt_rise_cnt = (reset || sync_n || rose) ? 4'h0 :
        rise_cnt_ff + {3'h0, rise_cnt_ff != 4'hF};
    assign nxt_rise_num = (reset || sync_n) ? 5'h00 :
        rise_num_ff + {4'h0, rose};
    // A channel counts as touched when any of its three fields moved.
    for (genvar i = 0; i < 4; i++) begin : g_chg
        assign chg[i] = (slew_enable[i] != p_en_ff[i])
            || (slew_update_rate[4*i+:4] != p_rate_ff[4*i+:4])
            || (slew_step_size[3*i+:3] != p_step_ff[3*i+:3]);
    end
    // Previous values and counter updates.
    always_ff @(posedge mclk) begin
        p_en_ff <= slew_enable;
        p_rate_ff <= slew_update_rate;
        p_step_ff <= slew_step_size;
        p_flt_ff <= flt;
        p_sclk_ff <= sclk;
        hi_cnt_ff <= nxt_hi_cnt;
        quiet_ff <= nxt_quiet;
        rise_cnt_ff <= nxt_rise_cnt;
        rise_num_ff <= nxt_rise_num;
    end
    // ==========================================================
    // Assertions.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence s_sclk_fall;
        sclk ##1 !sclk;
    endsequence
    a_pin_o_low: assert property (!fault_flag_pin_o)
        else $error("fault pin driven high");
    a_boost_no_oe: assert property (
        quiet_ff == 4'hF && $stable(flt) && $changed(boost_unregulated)
        |=> $stable(fault_flag_pin_oe) [*3])
        else $error("boost flag moved the fault pin");
    a_slew_frame_end: assert property (
        $changed({slew_enable, slew_update_rate, slew_step_size})
        |-> sync_n && hi_cnt_ff >= 4'h1 && hi_cnt_ff <= 4'hC)
        else $error("slew setting changed away from a frame end");
    a_slew_one_chan: assert property ($onehot0(chg))
        else $error("one write touched several channels");
    a_slew_mode_indep: assert property (
        $changed(current_mode) && hi_cnt_ff == 4'hF
        |=> $stable({slew_enable, slew_update_rate, slew_step_size}) [*2])
        else $error("output mode changed slew settings");
    a_slew_mid_frame: assert property (
        !sync_n && rise_num_ff != 5'h00
        |-> $stable({slew_enable, slew_update_rate, slew_step_size}))
        else $error("slew setting changed inside a frame");
    a_sdo_after_rise: assert property (
        !sync_n && rise_num_ff != 5'h00 && $changed(sdo)
        |-> rise_cnt_ff <= 4'h6)
        else $error("serial output moved away from a clock rise");
    a_sdo_lead_zero: assert property (
        s_sclk_fall ##0 (!sync_n && rise_num_ff >= 5'h01
        && rise_num_ff <= 5'h03) |-> !sdo)
        else $error("leading reply bits not zero");
endmodule // srbs_checker

bind srbs_top srbs_checker srbs_checker_inst (.mclk, .reset, .sclk,
    .sync_n, .sdo, .current_mode, .compliance_lost, .boost_unregulated,
    .vout_fault, .iout_short, .over_temp, .packet_check_fail,
    .fault_flag_pin_o, .fault_flag_pin_oe, .slew_enable,
    .slew_update_rate, .slew_step_size);

//--- tb/srbs_host_model.sv
// Host model: a serial master sending 24-bit frames, MSB first.
// Assumes a 40 ns mclk; one sclk period is eight mclk cycles.
`timescale 1ns/100ps
module srbs_host_model
    import srbs_pkg::*;
(
    // Clock.
    input wire logic mclk,
    // Serial pins.
    output logic sclk,
    output logic sync_n,
    output logic sdin,
    input wire logic sdo
);
    // Idle link: clock stands still low, frame select high.
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    // Reply bits are taken just before the next rise, where sdo is settled.
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        @(posedge mclk) #1 sync_n = 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 23; i >= 0; i--) begin
            #1 sdin = w[i];
            sclk = 1'b1;
            repeat (4) @(posedge mclk);
            #1 sclk = 1'b0;
            repeat (4) @(posedge mclk);
            r[i] = sdo;
        end
        #1 sync_n = 1'b1;
        sdin = ~sdin; // A released line must not keep its last value.
        repeat (12) @(posedge mclk);
    endtask
    // Read request with non-zero filler in the low data bits.
    function automatic logic [23:0] rd_frame(logic [1:0] a, logic [4:0] s);
        return {1'b1, a, s, 16'hC3A5};
    endfunction
    function automatic logic [23:0] nop_frame(logic [1:0] a);
        return NOP_FRAME | {1'b0, a, 21'h00_0000};
    endfunction
    // A read is always followed by a no-op that carries the reply out.
    task automatic read(logic [1:0] a, logic [4:0] s, output logic [23:0] r);
        xfer(rd_frame(a, s), r);
        xfer(nop_frame(a), r);
    endtask
endmodule // srbs_host_model

//--- tb/serial_readback_and_status_tb.sv
// Testbench: register map, slew settings and status word via the link.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module serial_readback_and_status_tb;
    import srbs_pkg::*;
    localparam logic [1:0] ADDR = 2'b01;
    localparam logic [2:0] WG [6] = '{WR_DATA, WR_CTRL, WR_GAIN, WR_OFFS,
        WR_CLR, WR_CTRL};
    logic mclk, reset, sclk, sync_n, sdin, sdo, over_temp;
    logic packet_check_fail, fault_flag_pin_o, fault_flag_pin_oe;
    logic [3:0] current_mode, compliance_lost, boost_unregulated;
    logic [3:0] vout_fault, iout_short, ramping, slew_enable, ex_en;
    logic [15:0] slew_update_rate, ex_rate;
    logic [11:0] slew_step_size, ex_step;
    logic [23:0] r;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    srbs_top srbs_top_inst (.mclk, .reset, .sclk, .sync_n, .sdin, .sdo,
        .device_addr_hi(ADDR[1]), .device_addr_lo(ADDR[0]), .current_mode,
        .compliance_lost, .boost_unregulated, .vout_fault, .iout_short,
        .over_temp, .packet_check_fail, .ramping, .fault_flag_pin_o,
        .fault_flag_pin_oe, .slew_enable, .slew_update_rate,
        .slew_step_size);
    srbs_host_model srbs_host_model_inst (.mclk, .sclk, .sync_n, .sdin,
        .sdo);
    // ==========================================================
    // Clock, timeout and reporting.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // About 100 frames of 210 cycles are expected; twice that is a hang.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(logic [23:0] got, logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // ==========================================================
    // Link access and helpers.
    task automatic wr(logic [2:0] g, logic [1:0] c, logic [15:0] d);
        srbs_host_model_inst.xfer({1'b0, ADDR, g, c, d}, r);
    endtask
    task automatic rd_chk(logic [4:0] s, logic [15:0] d);
        srbs_host_model_inst.read(ADDR, s, r);
        check(r, {3'b000, s, d});
    endtask
    task automatic chk_slew();
        check({8'h00, slew_update_rate}, {8'h00, ex_rate});
        check({8'h00, slew_enable, slew_step_size}, {8'h00, ex_en, ex_step});
    endtask
    task automatic mon(logic [3:0] cm, cl, bu, vf, is, rp, logic ot);
        @(posedge mclk) #1 current_mode = cm;
        compliance_lost = cl;
        boost_unregulated = bu;
        vout_fault = vf;
        iout_short = is;
        ramping = rp;
        over_temp = ot;
    endtask
    // Slew words leave bits 11 to 7 clear; other groups tag D15:13.
    function automatic logic [15:0] pat(int k, int c);
        if (k == 5) return {3'b000, c[0], 5'h00, 4'(c + 9), 3'(c + 5)};
        return {3'(k + 1), 1'b0, 4'(c), 8'h5A};
    endfunction
    // ==========================================================
    // Main sequence.
    initial begin
        logic [15:0] v;
        reset = 1'b1;
        packet_check_fail = 1'b0;
        mon(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
        ex_en = 4'h0;
        ex_rate = 16'h0000;
        ex_step = 12'h000;
        repeat (8) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (2) @(posedge mclk);
        check({22'h00_0000, fault_flag_pin_o, fault_flag_pin_oe}, 24'h00_0001);
        chk_slew();
        $display("test reset done");
        // Slew words go first, so later control writes must miss them.
        for (int q = 23; q >= 0; q--) begin
            wr(WG[q / 4], 2'(q % 4), pat(q / 4, q % 4));
        end
        wr(WR_MAIN, 2'd0, 16'h0123);
        wr(WR_BOOST, 2'd0, 16'h60C3);
        srbs_host_model_inst.xfer(srbs_host_model_inst.nop_frame(ADDR), r);
        for (int q = 0; q < 24; q++) begin
            v = pat(q / 4, q % 4);
            rd_chk(5'(q), v);
            ex_en[q % 4] = v[12];
        end
        rd_chk(SEL_MAIN, 16'h0123);
        rd_chk(SEL_BOOST, 16'h60C3);
        rd_chk(5'h1B, 16'h0000);
        ex_rate = 16'hCBA9;
        ex_step = 12'h1F5;
        chk_slew();
        $display("test register map done");
        wr(WR_CTRL, 2'd0, pat(5, 0) | 16'h0F80);
        chk_slew();
        srbs_host_model_inst.xfer({1'b0, ~ADDR, WR_CTRL, 2'd1, 16'h0000}, r);
        chk_slew();
        wr(WR_CTRL, 2'd2, 16'h1019);
        ex_en[2] = 1'b1;
        ex_rate[11:8] = 4'h3;
        ex_step[8:6] = 3'h1;
        chk_slew();
        repeat (20) @(posedge mclk);
        #1 current_mode = 4'hF;
        repeat (4) @(posedge mclk);
        chk_slew();
        $display("test slew done");
        mon(4'b0011, 4'b0001, 4'b0100, 4'b1000, 4'b0010, 4'hF, 1'b1);
        rd_chk(SEL_STATUS, 16'h5383);
        check({23'h00_0000, fault_flag_pin_oe}, 24'h00_0000);
        mon(4'b0011, 4'b0001, 4'b0100, 4'b1000, 4'b0010, 4'h1, 1'b1);
        rd_chk(SEL_STATUS, 16'h5183);
        wr(WR_SW, 2'd0, 16'h1000);
        rd_chk(SEL_STATUS, 16'h5983);
        wr(WR_MAIN, 2'd0, 16'h0800);
        #1 packet_check_fail = 1'b1;
        wr(WR_DATA, 2'd0, 16'h0000);
        wr(WR_DATA, 2'd0, 16'h0000);
        check({8'h00, r[15:0]}, 24'h00_5D83);
        #1 packet_check_fail = 1'b0;
        wr(WR_DATA, 2'd0, 16'h0000);
        wr(WR_DATA, 2'd0, 16'h0000);
        check({8'h00, r[15:0]}, 24'h00_5983);
        $display("test status done");
        mon(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
        repeat (20) @(posedge mclk);
        #1 boost_unregulated = 4'hF;
        repeat (10) @(posedge mclk);
        check({23'h00_0000, fault_flag_pin_oe}, 24'h00_0001);
        wr(WR_DATA, 2'd0, 16'h0000);
        check({8'h00, r[15:0]}, 24'h00_F800);
        $display("test boost flags done");
        end_sim();
    end
endmodule // serial_readback_and_status_tb
